// ### logic/lwbsp_pkg.sv
// Package of constants and carriers for the late-write burst SRAM port
package lwbsp_pkg;
  localparam int DATA_W_DEF  = 32;
  localparam int LANES_DEF   = 4;
  localparam int ADDR_W_DEF  = 10;
  localparam int SEED_W      = 2;
  localparam int LAT_PIPE    = 2;
  localparam int LAT_FLOW    = 1;
  localparam int BURST_LEN   = 4;

  typedef struct packed {
    logic       chip_sel1_n;
    logic       chip_sel_hi;
    logic       chip_sel3_n;
    logic       write_n;
    logic       advance_load;
    logic [3:0] lane_mask_n;
  } lwbsp_cmd_s;

  typedef enum logic [1:0] {
    LWBSP_OP_IDLE,
    LWBSP_OP_READ,
    LWBSP_OP_WRITE
  } lwbsp_op_e;
endpackage

// ### logic/lwbsp_port.sv
// Device-side logic of the late-write burst SRAM port with its core array
//
// Functional notes
// R1 - Synchronous inputs sampled only on rising edges
// R2 - Clock gate high freezes internal state except the sleep flag and output-enable release
// R3 - Host loads fresh address with advance_load low
// R4 - Selected only with all three selects active
// R5 - Read start: gate low, selected, write high, load
// R6 - Pipelined read data appears two edges after the command
// R7 - Write start: selected, gate active, write low
// R8 - Each byte mask controls its own lane
// R9 - All masks inactive: write is a no-op
// R10 - Pipelined write data taken two edges later
// R11 - Flow-through read latency one cycle shorter
// R12 - Flow-through write data taken next edge
// R13 - Start and burst logic same in both modes
// R14 - Matched latencies allow zero turnaround
// R15 - Output enable high releases data pins
// R16 - advance_load high steps burst counter
// R17 - Sleep request high puts device asleep
// R18 - flowthru_sel picks pipeline option
// R19 - Burst counter wraps after four addresses
// R20 - linear_order_n low gives linear order
// R21 - linear_order_n high gives interleaved order
// R22 - Data width and lane count are parameters
`timescale 1ns/100ps
module lwbsp_port #(
  parameter int DATA_W = lwbsp_pkg::DATA_W_DEF,
  parameter int LANES  = lwbsp_pkg::LANES_DEF,
  parameter int ADDR_W = lwbsp_pkg::ADDR_W_DEF
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // Command inputs
  input  wire logic                   clk_gate_n,
  input  wire lwbsp_pkg::lwbsp_cmd_s  cmd,
  input  wire logic [ADDR_W-1:0]      addr,
  // Mode and asynchronous controls
  input  wire logic                   flowthru_sel,
  input  wire logic                   linear_order_n,
  input  wire logic                   out_en_n,
  input  wire logic                   sleep_req,
  // Data pins
  input  wire logic [DATA_W-1:0]      data_in,
  output logic      [DATA_W-1:0]      data_out,
  output logic      [DATA_W-1:0]      data_oe,
  // Status
  output logic                        asleep
);
  localparam int LANE_W = DATA_W / LANES;
  localparam int DEPTH  = 1 << ADDR_W;

  initial begin
    if (LANES != 2 && LANES != 4) begin
      $error("lwbsp_port: lane count must be two or four");
    end
    if (DATA_W % LANES != 0) begin
      $error("lwbsp_port: data width must split evenly into lanes");
    end
    if (ADDR_W < 3) begin
      $error("lwbsp_port: address too narrow for a burst block");
    end
    // The two-bit step counter only serves a four-beat burst
    if ((1 << lwbsp_pkg::SEED_W) != lwbsp_pkg::BURST_LEN) begin
      $error("lwbsp_port: burst length does not match the seed width");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command decode
  logic                 selected;
  logic                 load_cmd;
  logic                 cont_cmd;
  logic                 go;
  logic [LANES-1:0]     mask_n;
  // Sleep and the gate both freeze the command decode
  assign go       = ~clk_gate_n & ~sleep_req; // R2 R17
  assign selected = ~cmd.chip_sel1_n & cmd.chip_sel_hi & ~cmd.chip_sel3_n; // R4
  assign load_cmd = go & ~cmd.advance_load & selected; // R3
  assign cont_cmd = go & cmd.advance_load;
  assign mask_n   = cmd.lane_mask_n[LANES-1:0]; // R22

  ////////////////////////////////////////////////////////////////////////////
  // Burst and command state
  logic [ADDR_W-1:0]    base_r, base_nxt;
  logic [1:0]           seed_r, seed_nxt;
  logic [1:0]           step_r, step_nxt;
  lwbsp_pkg::lwbsp_op_e op_r, op_nxt;
  logic [1:0]           burst_lsb;
  logic [1:0]           step_inc;
  logic [ADDR_W-1:0]    cur_addr;
  lwbsp_pkg::lwbsp_op_e cur_op;
  logic                 cur_valid;

  assign step_inc = step_r + 2'h1; // R19
  // Interleaved order is seed xor step, linear is seed plus step; both wrap in four
  always_comb begin
    if (linear_order_n) begin
      burst_lsb = seed_r ^ step_inc; // R21
    end else begin
      burst_lsb = seed_r + step_inc; // R20
    end
  end

  always_comb begin
    base_nxt  = base_r;
    seed_nxt  = seed_r;
    step_nxt  = step_r;
    op_nxt    = op_r;
    cur_addr  = '0;
    cur_op    = lwbsp_pkg::LWBSP_OP_IDLE;
    cur_valid = 1'b0;
    // A load with any select off parks the burst logic
    if (go && !cmd.advance_load) begin
      if (load_cmd) begin
        base_nxt  = addr;
        seed_nxt  = addr[lwbsp_pkg::SEED_W-1:0]; // R16
        step_nxt  = 2'h0;
        op_nxt    = cmd.write_n ? lwbsp_pkg::LWBSP_OP_READ
                                : lwbsp_pkg::LWBSP_OP_WRITE; // R5 R7 R13
        cur_addr  = addr;
        cur_op    = op_nxt;
        cur_valid = 1'b1;
      end else begin
        op_nxt = lwbsp_pkg::LWBSP_OP_IDLE;
      end
    // A continue after a deselect or after reset does nothing
    end else if (cont_cmd && op_r != lwbsp_pkg::LWBSP_OP_IDLE) begin
      step_nxt  = step_inc; // R16 R19
      cur_addr  = {base_r[ADDR_W-1:2], burst_lsb};
      cur_op    = op_r;
      cur_valid = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      base_r <= '0;
      seed_r <= 2'h0;
      step_r <= 2'h0;
      op_r   <= lwbsp_pkg::LWBSP_OP_IDLE;
    end else begin
      base_r <= base_nxt;
      seed_r <= seed_nxt;
      step_r <= step_nxt;
      op_r   <= op_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access pipeline; stage 1 is one edge after the command, stage 2 two
  logic                 rd1_r, rd1_nxt;
  logic                 wr1_r, wr1_nxt;
  logic                 wr2_r, wr2_nxt;
  logic [ADDR_W-1:0]    a1_r, a1_nxt;
  logic [ADDR_W-1:0]    a2_r, a2_nxt;
  logic [LANES-1:0]     m1_r, m1_nxt;
  logic [LANES-1:0]     m2_r, m2_nxt;

  always_comb begin
    rd1_nxt = rd1_r;
    wr1_nxt = wr1_r;
    wr2_nxt = wr2_r;
    a1_nxt  = a1_r;
    a2_nxt  = a2_r;
    m1_nxt  = m1_r;
    m2_nxt  = m2_r;
    if (go) begin
      rd1_nxt = cur_valid && cur_op == lwbsp_pkg::LWBSP_OP_READ;
      wr1_nxt = cur_valid && cur_op == lwbsp_pkg::LWBSP_OP_WRITE;
      a1_nxt  = cur_addr;
      // Masks are taken on continues too, so each beat picks its lanes
      m1_nxt  = ~mask_n; // R8
      // Second stage only matters for the pipelined late write
      wr2_nxt = wr1_r;
      a2_nxt  = a1_r;
      m2_nxt  = m1_r;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd1_r <= 1'b0;
      wr1_r <= 1'b0;
      wr2_r <= 1'b0;
      a1_r  <= '0;
      a2_r  <= '0;
      m1_r  <= '0;
      m2_r  <= '0;
    end else begin
      rd1_r <= rd1_nxt;
      wr1_r <= wr1_nxt;
      wr2_r <= wr2_nxt;
      a1_r  <= a1_nxt;
      a2_r  <= a2_nxt;
      m1_r  <= m1_nxt;
      m2_r  <= m2_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core array and late write
  // Core contents are not cleared by reset
  logic [DATA_W-1:0]    mem [DEPTH];
  logic                 wr_now;
  logic [ADDR_W-1:0]    wr_addr;
  logic [LANES-1:0]     wr_lanes;
  // Flow-through takes data one edge after the command, pipeline two
  always_comb begin
    if (flowthru_sel) begin
      wr_now   = go & wr1_r; // R12
      wr_addr  = a1_r;
      wr_lanes = m1_r;
    end else begin
      wr_now   = go & wr2_r; // R10 R14
      wr_addr  = a2_r;
      wr_lanes = m2_r;
    end
  end

  // Per-lane write keeps masked bytes untouched
  for (genvar l = 0; l < LANES; l++) begin : g_lane
    always_ff @(posedge clk) begin
      if (wr_now && wr_lanes[l]) begin // R8 R9
        mem[wr_addr][l*LANE_W +: LANE_W] <= data_in[l*LANE_W +: LANE_W]; // R1
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data path and drivers
  logic [DATA_W-1:0]    rdata_r, rdata_nxt;
  logic                 rvalid_r, rvalid_nxt;
  logic [DATA_W-1:0]    dout_r, dout_nxt;
  logic                 drive_r, drive_nxt;
  logic                 oe_nxt;
  logic [ADDR_W-1:0]    rd_addr;
  logic                 rd_now;
  logic [DATA_W-1:0]    core_rd;

  // Flow-through reads the core at the command edge, pipeline one edge later
  always_comb begin
    if (flowthru_sel) begin
      rd_now  = cur_valid && cur_op == lwbsp_pkg::LWBSP_OP_READ; // R11
      rd_addr = cur_addr;
    end else begin
      rd_now  = rd1_r; // R6
      rd_addr = a1_r;
    end
  end

  // A late write lands on the very edge that reads the core; forward its
  // bytes so a read right behind a write to the same word is not stale
  for (genvar f = 0; f < LANES; f++) begin : g_fwd
    assign core_rd[f*LANE_W +: LANE_W] = (wr_now && wr_lanes[f] && wr_addr == rd_addr) // R14
        ? data_in[f*LANE_W +: LANE_W]
        : mem[rd_addr][f*LANE_W +: LANE_W];
  end

  always_comb begin
    rdata_nxt  = rdata_r;
    rvalid_nxt = rvalid_r;
    dout_nxt   = dout_r;
    drive_nxt  = drive_r;
    // Sleep wins over the clock gate and drops the drivers at once
    if (sleep_req) begin
      drive_nxt = 1'b0; // R17
    end else if (go) begin
      rvalid_nxt = rd_now;
      if (rd_now) begin
        rdata_nxt = core_rd;
      end
      // One shared output stage; flow-through simply feeds it an edge sooner
      dout_nxt  = rvalid_r ? rdata_r : dout_r; // R6 R11 R13
      drive_nxt = rvalid_r & ~out_en_n; // R15
    end else if (out_en_n) begin
      drive_nxt = 1'b0; // R15
    end
    // Enable is registered, so release lags out_en_n by one edge
    oe_nxt = drive_nxt & ~out_en_n & ~sleep_req; // R15
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_r  <= '0;
      rvalid_r <= 1'b0;
      dout_r   <= '0;
      drive_r  <= 1'b0;
      data_oe  <= '0;
      data_out <= '0;
      asleep   <= 1'b0;
    end else begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      dout_r   <= dout_nxt;
      drive_r  <= drive_nxt;
      asleep   <= sleep_req; // R17
      data_out <= dout_nxt;
      data_oe  <= {DATA_W{oe_nxt}}; // R15
    end
  end
endmodule

// ### test/lwbsp_port_monitor.sv
// Assertion checker for the burst SRAM port
`timescale 1ns/100ps
module lwbsp_port_monitor #(
  parameter int DATA_W = 32
) (
  // Clock and commands
  input wire logic                  clk,
  input wire logic                  rst,
  input wire logic                  clk_gate_n,
  input wire lwbsp_pkg::lwbsp_cmd_s cmd,
  // Modes and pins
  input wire logic                  flowthru_sel,
  input wire logic                  out_en_n,
  input wire logic                  sleep_req,
  input wire logic [DATA_W-1:0]     data_out,
  input wire logic [DATA_W-1:0]     data_oe,
  input wire logic                  asleep
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire run = !clk_gate_n && !sleep_req;
  wire sel = !cmd.chip_sel1_n && cmd.chip_sel_hi && !cmd.chip_sel3_n;
  wire ld  = run && !cmd.advance_load;
  sequence s_rd_p; ld && sel && cmd.write_n && !flowthru_sel; endsequence
  sequence s_rd_f; ld && sel && cmd.write_n && flowthru_sel; endsequence
  sequence s_wr_p; ld && sel && !cmd.write_n && !flowthru_sel; endsequence
  sequence s_des; ld && !sel && !flowthru_sel; endsequence
  a_rd_pipe: assert property (s_rd_p ##1 run ##1 (run && !out_en_n) |=> data_oe == '1)
    else $error("pipelined read not driven");
  a_rd_flow: assert property (s_rd_f ##1 (run && !out_en_n) |=> data_oe == '1)
    else $error("flow read not driven");
  a_wr_quiet: assert property (s_wr_p ##1 run ##1 run |=> data_oe == '0)
    else $error("write beat drove bus");
  a_desel_quiet: assert property (s_des ##1 run ##1 run |=> data_oe == '0)
    else $error("deselect drove bus");
  a_oe_release: assert property (out_en_n && run |=> data_oe == '0)
    else $error("bus driven with enable off");
  a_sleep_drop: assert property (sleep_req |=> asleep && data_oe == '0)
    else $error("sleep not entered");
  a_sleep_wake: assert property (!sleep_req |=> !asleep)
    else $error("sleep not left");
  a_stall_hold: assert property (clk_gate_n && !sleep_req |=> $stable(data_out))
    else $error("gated edge moved data");
endmodule
bind lwbsp_port lwbsp_port_monitor #(.DATA_W(DATA_W)) u_lwbsp_port_monitor (.clk, .rst,
  .clk_gate_n, .cmd, .flowthru_sel, .out_en_n, .sleep_req, .data_out, .data_oe, .asleep);

// ### test/lwbsp_host.sv
// Host controller model issuing commands and late write data
`timescale 1ns/100ps
module lwbsp_host (
  // Clock and mode
  input wire logic        clk,
  input wire logic        ft,
  // Bus to the port
  output lwbsp_pkg::lwbsp_cmd_s cmd,
  output logic [9:0]      addr,
  output logic [31:0]     din,
  output logic            gate_n
);
  logic        iw = 1'b0;
  logic        qw = 1'b0;
  logic [31:0] id = 32'h0;
  logic [31:0] qd = 32'h0;
  initial begin
    cmd = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 4'hF};
    addr = 10'h0;
    din = 32'h0;
    gate_n = 1'b0;
  end
  // Gated edges hold the data schedule back too
  always @(posedge clk) begin
    if (!gate_n) begin
      qw <= iw;
      qd <= id;
      // Idle bus toggles so a stale value never looks valid
      din <= (ft ? iw : qw) ? (ft ? id : qd) : ~din;
    end
  end
  task send(input logic g, s, w, v, input logic [3:0] m, input logic [9:0] a,
            input logic [31:0] d);
    @(posedge clk);
    gate_n <= g;
    cmd <= '{!s, s, !s, !w, v, m};
    addr <= a;
    iw <= s && w && !v;
    id <= d;
  endtask
endmodule

// ### test/lwbsp_port_tb_top.sv
// Testbench of the burst SRAM port
`timescale 1ns/100ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module lwbsp_port_tb_top;
  logic clk = 1'b0, rst = 1'b1, ft = 1'b0, lin_n = 1'b0, oe_n = 1'b0, slp = 1'b0;
  lwbsp_pkg::lwbsp_cmd_s cmd;
  logic [9:0] addr;
  logic [31:0] din, dout, doe;
  logic gate_n, asl;
  int n_errors = 0, checked = 0;
  initial forever #2.5 clk = ~clk;
  lwbsp_host u_lwbsp_host (.clk, .ft, .cmd, .addr, .din, .gate_n);
  lwbsp_port u_lwbsp_port (.clk, .rst, .clk_gate_n(gate_n), .cmd, .addr, .flowthru_sel(ft),
    .linear_order_n(lin_n), .out_en_n(oe_n), .sleep_req(slp), .data_in(din), .data_out(dout),
    .data_oe(doe), .asleep(asl));
  task c(input logic g, s, w, v, input logic [3:0] m, input logic [9:0] a, input logic [31:0] d);
    u_lwbsp_host.send(g, s, w, v, m, a, d);
  endtask
  task nop;
    c(0, 0, 0, 0, 4'hF, 10'h0, 32'h0);
  endtask
  task do_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
  endtask
  task t_rw;
    int lat;
    lat = ft ? lwbsp_pkg::LAT_FLOW : lwbsp_pkg::LAT_PIPE;
    c(0, 1, 1, 0, 4'h0, 10'h005, 32'h1111_1111);
    c(0, 1, 1, 0, 4'h0, 10'h006, 32'h2222_2222);
    c(0, 1, 1, 0, 4'hA, 10'h006, 32'h3333_3333);
    c(0, 1, 1, 0, 4'hF, 10'h006, 32'h4444_4444);
    c(0, 1, 0, 0, 4'hF, 10'h006, 32'h0);
    c(0, 1, 0, 0, 4'hF, 10'h005, 32'h0);
    nop;
    repeat (lat - 1) @(posedge clk);
    #1 `CHK("rd6", 32'h2233_2233, dout)
    @(posedge clk);
    #1 `CHK("rd5", 32'h1111_1111, dout)
    `CHK("oe", '1, doe)
  endtask
  task t_stall;
    repeat (2) nop;
    c(0, 1, 0, 0, 4'hF, 10'h005, 32'h0);
    repeat (2) c(1, 0, 0, 0, 4'hF, 10'h0, 32'h0);
    nop;
    @(posedge clk);
    #1 `CHK("stall_oe", '0, doe)
    @(posedge clk);
    #1 `CHK("stall_rd", 32'h1111_1111, dout)
  endtask
  task t_burst(input logic l);
    lin_n <= l;
    for (int k = 0; k < 4; k++) c(0, 1, 1, 0, 4'h0, 10'h008 + 10'(k), 32'h100 + 32'(k));
    fork
      for (int i = 0; i < 5; i++) c(0, 1, 0, i != 0, 4'hF, 10'h009, 32'h0);
      begin
        repeat (4) @(posedge clk);
        for (int i = 0; i < 5; i++) begin
          #1 `CHK("burst", 32'h100 + 32'((l ? 1 ^ i : 1 + i) % 4), dout)
          @(posedge clk);
        end
      end
    join
    nop;
  endtask
  task t_pins;
    oe_n <= 1'b1;
    c(0, 1, 0, 0, 4'hF, 10'h005, 32'h0);
    nop;
    repeat (2) @(posedge clk);
    #1 `CHK("oe_off", '0, doe)
    slp <= 1'b1;
    oe_n <= 1'b0;
    c(0, 1, 0, 0, 4'hF, 10'h005, 32'h0);
    nop;
    repeat (2) @(posedge clk);
    #1 `CHK("asleep", 1'b1, asl)
    `CHK("sleep_oe", '0, doe)
    @(posedge clk);
    slp <= 1'b0;
  endtask
  task conclude;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #20000;
    n_errors++;
    conclude;
  end
  initial begin
    do_reset;
    t_rw;
    t_stall;
    t_burst(1'b0);
    t_burst(1'b1);
    t_pins;
    ft <= 1'b1;
    do_reset;
    t_rw;
    conclude;
  end
endmodule
